// ===== src/hbsfh_regs.svh
`ifndef HBSFH_REGS_SVH
`define HBSFH_REGS_SVH

// Clock rates
`define HBSFH_REF_CLK_MHZ 25
`define HBSFH_REF_CLK_KHZ 25000
`define HBSFH_REF_CLK_NS 40
`define HBSFH_SYS_CLK_MHZ 5

// Select recognition and glitch filter
`define HBSFH_START_SYS_CYCLES 4
`define HBSFH_START_CYCLES (`HBSFH_START_SYS_CYCLES * `HBSFH_REF_CLK_MHZ / `HBSFH_SYS_CLK_MHZ)
`define HBSFH_SEL_FILT_NS 40
`define HBSFH_SEL_FILT_CYCLES ((`HBSFH_SEL_FILT_NS + `HBSFH_REF_CLK_NS - 1) / `HBSFH_REF_CLK_NS)
`define HBSFH_FILT_CYCLES ((`HBSFH_START_CYCLES > `HBSFH_SEL_FILT_CYCLES) ? \
  `HBSFH_START_CYCLES : `HBSFH_SEL_FILT_CYCLES)

// Frame layout
`define HBSFH_FRAME_BITS 16
`define HBSFH_FRAME_MOD_MASK 4'hf

// Command addresses and data patterns
`define HBSFH_ADDR_UNUSED 4'h0
`define HBSFH_ADDR_LEVEL 4'h5
`define HBSFH_ADDR_RSVD_A 4'ha
`define HBSFH_ADDR_RSVD_B 4'hb
`define HBSFH_ADDR_TRACE 4'hd
`define HBSFH_ADDR_IDENT 4'hf
`define HBSFH_DATA_TRACE_LO 11'h000
`define HBSFH_DATA_TRACE_HI 11'h001
`define HBSFH_DATA_IDENT 11'h000
`define HBSFH_LEVEL_ZERO_MASK 11'h03e
`define HBSFH_LEVEL_RESET 4'hf
`define HBSFH_LEVEL_MSB 10
`define HBSFH_LEVEL_LSB 7
`define HBSFH_TRACE_HALF 12
`define HBSFH_ERROR_ANSWER 16'h0000

// Communication check timer
`define HBSFH_TCC_MS 54
`define HBSFH_TCC_FIRST_MULT 2

`endif

// ===== src/hbsfh_pkg.sv
package hbsfh_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [10:0] data;
    logic parity;
  } hbsfh_cmd_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [11:0] payload;
  } hbsfh_answer_t;

  typedef enum logic [0:0] {
    HBSFH_IDLE = 1'b0,
    HBSFH_FRAME = 1'b1
  } hbsfh_state_t;

endpackage : hbsfh_pkg

// ===== src/hbsfh_frame_handler.sv
`timescale 1ns/1ps
`include "hbsfh_regs.svh"

// Behaviour
// - Frame start needs four slow-clock periods low
// - Select low re-drives previous last bit
// - Output released while select high
// - Works with slow or stopped link clock
// - Short select glitches are ignored
// - Data in captured on falling clock edge
// - Address 0101 loads four-bit level field
// - Address 1101 returns traceability halves
// - Odd parity checked; answers carry none
// - Errors and first answer are all zero
// - Command acted on at select release only
// - Comm-check timeout clears pass, disables bridge
module hbsfh_frame_handler
  import hbsfh_pkg::*;
#(
  parameter int unsigned P_TCC_CYCLES = `HBSFH_TCC_MS * `HBSFH_REF_CLK_KHZ,
  parameter logic [11:0] P_CHIP_NAME = 12'h5a4, // Arbitrary value
  parameter int unsigned P_CNT_W = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_spi_clk,
  input wire logic i_select_low,
  input wire logic i_spi_mosi,
  input wire logic [23:0] i_trace_id,
  input wire logic i_comm_check_enable,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  output logic [3:0] o_level_value,
  output logic o_level_config_trigger,
  output logic o_comm_check_pass_flag,
  output logic o_bridge_off,
  output logic o_frame_valid
);

  localparam int unsigned FILT_W = 5;
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(`HBSFH_FILT_CYCLES - 1);
  localparam int unsigned TCC_W = 23;
  localparam logic [TCC_W-1:0] TCC_LOAD = TCC_W'(P_TCC_CYCLES - 1);
  localparam logic [TCC_W-1:0] TCC_FIRST = TCC_W'(`HBSFH_TCC_FIRST_MULT * P_TCC_CYCLES - 1);

  // Link-clock domain: shift-in, edge count, shift-out
  logic [`HBSFH_FRAME_BITS-1:0] lk_shift_q;
  logic [P_CNT_W-1:0] lk_cnt_q;
  logic miso_q;
  logic [3:0] lk_idx;

  // System domain
  logic sel_s1_q, sel_s2_q;
  logic [`HBSFH_FRAME_BITS-1:0] sh_s1_q, sh_s2_q;
  logic [P_CNT_W-1:0] cnt_s1_q, cnt_s2_q;
  logic [FILT_W-1:0] filt_cnt_q;
  logic sel_high_q;
  hbsfh_state_t state_q;
  logic [P_CNT_W-1:0] start_cnt_q;
  hbsfh_answer_t answer_q;
  logic oe_q;
  logic [3:0] level_q;
  logic level_trig_q;
  logic valid_q;
  logic pass_q;
  logic bridge_off_q;
  logic first_q;
  logic [TCC_W-1:0] tcc_q;

  logic sel_rise, sel_fall;
  hbsfh_cmd_t cmd;
  logic [P_CNT_W-1:0] nclk;
  logic count_ok, parity_ok, reserved, frame_ok;
  hbsfh_answer_t answer_d;
  logic level_hit;

  always_ff @(negedge i_spi_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lk_shift_q <= '0;
      lk_cnt_q <= '0;
    end else begin
      lk_shift_q <= {lk_shift_q[`HBSFH_FRAME_BITS-2:0], i_spi_mosi};
      lk_cnt_q <= lk_cnt_q + 1'b1;
    end
  end

  // The answer only changes at select release and the start count at select fall, both while the link
  // clock idles, so they are stable whenever the link clock runs here.
  assign lk_idx = 4'(lk_cnt_q - start_cnt_q);

  always_ff @(posedge i_spi_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= answer_q[~lk_idx];
    end
  end

  // The pin holds its level until the next rising edge, so the last bit of
  // the previous frame is what shows when select falls again.
  assign o_spi_miso = miso_q;

  // Synchronisers: the link words are quasi-static once select is seen high
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      sel_s1_q <= 1'b1;
      sel_s2_q <= 1'b1;
      sh_s1_q <= '0;
      sh_s2_q <= '0;
      cnt_s1_q <= '0;
      cnt_s2_q <= '0;
    end else begin
      sel_s1_q <= i_select_low;
      sel_s2_q <= sel_s1_q;
      sh_s1_q <= lk_shift_q;
      sh_s2_q <= sh_s1_q;
      cnt_s1_q <= lk_cnt_q;
      cnt_s2_q <= cnt_s1_q;
    end
  end

  // Select needs a run of equal samples before it counts; this covers both
  // the short-glitch filter and the slow-clock start recognition.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      filt_cnt_q <= '0;
      sel_high_q <= 1'b1;
    end else if (sel_s2_q == sel_high_q) begin
      filt_cnt_q <= '0;
    end else if (filt_cnt_q == FILT_LAST) begin
      filt_cnt_q <= '0;
      sel_high_q <= sel_s2_q;
    end else begin
      filt_cnt_q <= filt_cnt_q + 1'b1;
    end
  end

  assign sel_fall = sel_high_q && (sel_s2_q == 1'b0) && (filt_cnt_q == FILT_LAST);
  assign sel_rise = !sel_high_q && sel_s2_q && (filt_cnt_q == FILT_LAST);

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state_q <= HBSFH_IDLE;
      start_cnt_q <= '0;
    end else begin
      unique case (state_q)
        HBSFH_IDLE: begin
          if (sel_fall) begin
            state_q <= HBSFH_FRAME;
            start_cnt_q <= cnt_s2_q;
          end
        end
        HBSFH_FRAME: begin
          if (sel_rise) begin
            state_q <= HBSFH_IDLE;
          end
        end
      endcase
    end
  end

  // Output enable follows the filtered select; the filter delay exceeds the
  // pin timing, a limitation of running the decision on the slow clock.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      oe_q <= 1'b0;
    end else if (sel_fall) begin
      oe_q <= 1'b1;
    end else if (sel_rise) begin
      oe_q <= 1'b0;
    end
  end

  assign o_spi_miso_oe = oe_q;

  // Frame checks
  assign cmd = hbsfh_cmd_t'(sh_s2_q);
  assign nclk = cnt_s2_q - start_cnt_q;
  assign count_ok = (nclk != '0) && ((nclk[3:0] & `HBSFH_FRAME_MOD_MASK) == 4'h0);
  assign parity_ok = ^sh_s2_q;
  assign reserved = (cmd.addr == `HBSFH_ADDR_UNUSED) || (cmd.addr == `HBSFH_ADDR_RSVD_A)
    || (cmd.addr == `HBSFH_ADDR_RSVD_B);
  assign level_hit = (cmd.addr == `HBSFH_ADDR_LEVEL)
    && ((cmd.data & `HBSFH_LEVEL_ZERO_MASK) == 11'h000);

  always_comb begin
    answer_d = `HBSFH_ERROR_ANSWER;
    frame_ok = 1'b0;
    if (count_ok && parity_ok && !reserved) begin
      frame_ok = 1'b1;
      answer_d.addr = cmd.addr;
      if (cmd.addr == `HBSFH_ADDR_TRACE) begin
        if (cmd.data == `HBSFH_DATA_TRACE_LO) begin
          answer_d.payload = i_trace_id[`HBSFH_TRACE_HALF-1:0];
        end else if (cmd.data == `HBSFH_DATA_TRACE_HI) begin
          answer_d.payload = i_trace_id[2*`HBSFH_TRACE_HALF-1:`HBSFH_TRACE_HALF];
        end else begin
          answer_d = `HBSFH_ERROR_ANSWER;
          frame_ok = 1'b0;
        end
      end else if (cmd.addr == `HBSFH_ADDR_IDENT && cmd.data == `HBSFH_DATA_IDENT) begin
        answer_d.payload = P_CHIP_NAME;
      end else if (cmd.addr == `HBSFH_ADDR_LEVEL && !level_hit) begin
        answer_d = `HBSFH_ERROR_ANSWER;
        frame_ok = 1'b0;
      end
    end
  end

  // Act on the command only at the filtered select release; a select low
  // with no clocks is dropped and keeps the previous answer.
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      answer_q <= `HBSFH_ERROR_ANSWER;
      valid_q <= 1'b0;
    end else begin
      valid_q <= 1'b0;
      if (sel_rise && state_q == HBSFH_FRAME && nclk != '0) begin
        answer_q <= answer_d;
        valid_q <= frame_ok;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      level_q <= `HBSFH_LEVEL_RESET;
      level_trig_q <= 1'b0;
    end else begin
      level_trig_q <= 1'b0;
      if (sel_rise && state_q == HBSFH_FRAME && frame_ok && level_hit) begin
        level_q <= cmd.data[`HBSFH_LEVEL_MSB:`HBSFH_LEVEL_LSB];
        level_trig_q <= 1'b1;
      end
    end
  end

  // The window stays doubled after reset until the first good frame,
  // whether or not checking is enabled at that time
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      first_q <= 1'b1;
    end else if (valid_q) begin
      first_q <= 1'b0;
    end
  end

  // Disabled checking keeps reloading, so enabling starts a full window
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      tcc_q <= TCC_FIRST;
      pass_q <= 1'b1;
      bridge_off_q <= 1'b0;
    end else if (!i_comm_check_enable) begin
      tcc_q <= first_q ? TCC_FIRST : TCC_LOAD;
      pass_q <= 1'b1;
      bridge_off_q <= 1'b0;
    end else if (valid_q) begin
      tcc_q <= TCC_LOAD;
    end else if (tcc_q == '0) begin
      pass_q <= 1'b0;
      bridge_off_q <= 1'b1;
    end else begin
      tcc_q <= tcc_q - 1'b1;
    end
  end

  assign o_level_value = level_q;
  assign o_level_config_trigger = level_trig_q;
  assign o_comm_check_pass_flag = pass_q;
  assign o_bridge_off = bridge_off_q;
  assign o_frame_valid = valid_q;

endmodule : hbsfh_frame_handler

// ===== verif/hbsfh_asserts.sv
`timescale 1ns/1ps
module hbsfh_asserts (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_select_low,
  input wire logic i_comm_check_enable,
  input wire logic o_spi_miso_oe,
  input wire logic [3:0] o_level_value,
  input wire logic o_level_config_trigger,
  input wire logic o_comm_check_pass_flag,
  input wire logic o_bridge_off,
  input wire logic o_frame_valid
);
  logic sel_q;
  logic [5:0] run_q;
  // Saturates so that a long idle never wraps back into the window
  always_ff @(posedge i_ref_clk) begin
    sel_q <= i_select_low;
    if (i_sys_rst || i_select_low != sel_q) run_q <= 6'h00;
    else if (run_q != 6'h3f) run_q <= run_q + 6'h01;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence cc_off_s;
    !i_comm_check_enable ##1 !i_comm_check_enable;
  endsequence
  oe_on_a: assert property (!i_select_low && run_q == 6'd26 |-> o_spi_miso_oe)
    else $error("output not enabled");
  oe_off_a: assert property (i_select_low && run_q == 6'd26 |-> !o_spi_miso_oe)
    else $error("output still enabled");
  oe_late_a: assert property ($rose(o_spi_miso_oe) |-> !i_select_low && run_q >= 6'd19)
    else $error("select taken too early");
  oe_drop_a: assert property ($fell(o_spi_miso_oe) |-> i_select_low && run_q >= 6'd19)
    else $error("output dropped too early");
  act_release_a: assert property (o_frame_valid |-> i_select_low && run_q >= 6'd19)
    else $error("frame acted on early");
  valid_pulse_a: assert property (o_frame_valid |=> !o_frame_valid)
    else $error("valid longer than a cycle");
  level_trig_a: assert property ($changed(o_level_value) |-> o_level_config_trigger)
    else $error("level changed without trigger");
  cc_idle_a: assert property (cc_off_s |-> o_comm_check_pass_flag && !o_bridge_off)
    else $error("check active while disabled");
  bridge_pass_a: assert property (o_bridge_off |-> !o_comm_check_pass_flag)
    else $error("bridge off with pass set");
endmodule : hbsfh_asserts

bind hbsfh_frame_handler hbsfh_asserts hbsfh_asserts_inst (.i_ref_clk, .i_sys_rst,
  .i_select_low, .i_comm_check_enable, .o_spi_miso_oe, .o_level_value,
  .o_level_config_trigger, .o_comm_check_pass_flag, .o_bridge_off, .o_frame_valid);

// ===== verif/hbsfh_host.sv
`timescale 1ns/1ps
module hbsfh_host (
  input wire logic i_spi_miso,
  input wire logic i_spi_miso_oe,
  output logic o_spi_clk,
  output logic o_select_low,
  output logic o_spi_mosi
);
  // Released output reads inverted so a missing enable cannot pass
  wire logic line = i_spi_miso_oe ? i_spi_miso : ~i_spi_miso;
  initial begin
    o_spi_clk = 1'b0;
    o_select_low = 1'b1;
    o_spi_mosi = 1'b1;
  end
  task automatic xfer(input logic [31:0] w, input int n, output logic [15:0] r, output logic pre);
    r = 16'h0000;
    #7 o_select_low = 1'b0;
    #1100 pre = line;
    for (int i = n - 1; i >= 0; i--) begin
      o_spi_clk = 1'b1;
      o_spi_mosi = w[i];
      #15 r = {r[14:0], line};
      o_spi_clk = 1'b0;
      #15;
    end
    #15 o_spi_mosi = 1'b1;
    #100 o_select_low = 1'b1;
    #1200;
  endtask : xfer
endmodule : hbsfh_host

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
  localparam logic [23:0] TRACE = 24'h9c36b1;
  localparam logic [11:0] NAME = 12'h3c9; // Arbitrary value
  localparam int unsigned TCC = 200;
  localparam logic [15:0] LO = {4'hd, 11'h000, 1'b0};
  localparam logic [15:0] HI = {4'hd, 11'h001, 1'b1};
  localparam logic [15:0] A_LO = {4'hd, TRACE[11:0]};
  localparam logic [15:0] A_HI = {4'hd, TRACE[23:12]};
  logic i_ref_clk, i_sys_rst, i_comm_check_enable, spi_clk, sel_host, mosi, glitch_q, last_q;
  logic o_spi_miso, o_spi_miso_oe, o_level_config_trigger;
  logic o_comm_check_pass_flag, o_bridge_off, o_frame_valid;
  logic [3:0] o_level_value;
  logic [15:0] exp_q;
  int miscompares, total_checks, valid_n, trig_n;
  wire logic sel = sel_host & ~glitch_q;
  hbsfh_frame_handler #(.P_TCC_CYCLES(TCC), .P_CHIP_NAME(NAME)) hbsfh_frame_handler_inst (
    .i_ref_clk, .i_sys_rst,
    .i_spi_clk(spi_clk), .i_select_low(sel), .i_spi_mosi(mosi), .i_trace_id(TRACE),
    .i_comm_check_enable, .o_spi_miso, .o_spi_miso_oe, .o_level_value,
    .o_level_config_trigger, .o_comm_check_pass_flag, .o_bridge_off, .o_frame_valid);
  hbsfh_host hbsfh_host_inst (.i_spi_miso(o_spi_miso), .i_spi_miso_oe(o_spi_miso_oe),
    .o_spi_clk(spi_clk), .o_select_low(sel_host), .o_spi_mosi(mosi));
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    if (o_frame_valid === 1'b1) valid_n++;
    if (o_level_config_trigger === 1'b1) trig_n++;
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic frame(input logic [31:0] w, input int n, input logic [15:0] nxt, input int ok);
    logic [15:0] r;
    logic pre;
    int v0;
    v0 = valid_n;
    hbsfh_host_inst.xfer(w, n, r, pre);
    chk("last bit", 16'(pre), 16'(last_q));
    if (n == 16) chk("answer", r, exp_q);
    if (n > 0) begin
      last_q = r[0];
      exp_q = nxt;
    end
    chk("frames", 16'(valid_n - v0), 16'(ok));
  endtask : frame
  task automatic t_level();
    frame({4'h5, 11'h300, 1'b1}, 16, 16'h5000, 1);
    chk("level", 16'(o_level_value), 16'h0006);
    chk("trigger", 16'(trig_n), 16'h0001);
    frame({4'h5, 11'h302, 1'b0}, 16, 16'h0000, 0);
    chk("level", 16'(o_level_value), 16'h0006);
    chk("trigger", 16'(trig_n), 16'h0001);
  endtask : t_level
  task automatic t_errors();
    logic [15:0] bad [4];
    bad = '{{4'hd, 11'h000, 1'b1}, {4'ha, 11'h000, 1'b1},
      {4'h0, 11'h000, 1'b1}, {4'hd, 11'h002, 1'b1}};
    foreach (bad[i]) frame(bad[i], 16, 16'h0000, 0);
  endtask : t_errors
  task automatic t_counts();
    frame(LO, 15, 16'h0000, 0);
    frame({16'ha5a5, HI}, 32, A_HI, 1);
    frame(32'h0, 0, 16'h0000, 0);
    frame(LO, 16, A_LO, 1);
  endtask : t_counts
  task automatic t_glitch();
    int v0;
    v0 = valid_n;
    @(posedge i_ref_clk) glitch_q <= 1'b1;
    @(posedge i_ref_clk) glitch_q <= 1'b0;
    repeat (30) @(posedge i_ref_clk);
    chk("glitch", 16'(valid_n - v0), 16'h0000);
    frame(HI, 16, A_HI, 1);
  endtask : t_glitch
  task automatic t_cc();
    int i;
    @(posedge i_ref_clk) i_comm_check_enable <= 1'b1;
    for (i = 0; i < TCC + 60 && o_bridge_off !== 1'b1; i++) @(posedge i_ref_clk);
    chk("timeout", {o_bridge_off, o_comm_check_pass_flag}, 16'h0002);
    i_comm_check_enable <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    chk("check off", {o_bridge_off, o_comm_check_pass_flag}, 16'h0001);
  endtask : t_cc
  task automatic t_idle();
    logic [6:0] s;
    s = {o_level_value, o_comm_check_pass_flag, o_bridge_off, o_spi_miso_oe};
    chk("idle", 16'(s), 16'h007c);
  endtask : t_idle
  task automatic t_ident();
    frame({4'hf, 11'h000, 1'b1}, 16, {4'hf, NAME}, 1);
    frame({4'h1, 11'h000, 1'b0}, 16, 16'h1000, 1);
  endtask : t_ident
  task automatic t_first();
    int i;
    i_sys_rst <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    i_comm_check_enable <= 1'b1;
    last_q = 1'b0;
    exp_q = 16'h0000;
    @(posedge i_ref_clk);
    t_idle();
    repeat (TCC + TCC / 2) @(posedge i_ref_clk);
    chk("first window", {o_bridge_off, o_comm_check_pass_flag}, 16'h0001);
    for (i = 0; i < TCC && o_bridge_off !== 1'b1; i++) @(posedge i_ref_clk);
    chk("late timeout", {o_bridge_off, o_comm_check_pass_flag}, 16'h0002);
  endtask : t_first
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  initial begin
    i_sys_rst = 1'b1;
    i_comm_check_enable = 1'b0;
    glitch_q = 1'b0;
    last_q = 1'b0;
    exp_q = 16'h0000;
    repeat (4) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_ref_clk);
    t_idle();
    frame(LO, 16, A_LO, 1);
    frame(HI, 16, A_HI, 1);
    t_ident();
    t_level();
    t_errors();
    t_counts();
    t_glitch();
    t_cc();
    t_first();
    wrap_up();
  end
endmodule : tb
